// File: core/event_counter_map.vh
// register offsets, field codes and timing counts for the dual event counter
`ifndef EVENT_COUNTER_MAP_VH
`define EVENT_COUNTER_MAP_VH

// apb byte offsets
`define OFS_UNIT_SELECT 8'h00
`define OFS_INC_SRC 8'h04
`define OFS_INC_ACT 8'h08
`define OFS_START_LIMIT 8'h0C
`define OFS_END_LIMIT 8'h10
`define OFS_START_SRC 8'h14
`define OFS_START_ACT 8'h18
`define OFS_STOP_SRC 8'h1C
`define OFS_STOP_ACT 8'h20
`define OFS_LIVE_COUNT 8'h24
`define OFS_CAPTURED 8'h28
`define OFS_UNIT_STATE 8'h2C
`define OFS_CONTROL 8'h30
`define OFS_IRQ_STATUS 8'h34
`define OFS_IRQ_MASK 8'h38

// event source codes, also bit positions of the event vector
`define SRC_OFF 5'h00
`define SRC_TICK 5'h01
`define SRC_A_BEGIN 5'h0A
`define SRC_B_FINISH 5'h0D
`define SRC_LAST 5'h12

// activation modes
`define ACT_LOW 3'h0
`define ACT_HIGH 3'h1
`define ACT_FALL 3'h2
`define ACT_RISE 3'h3
`define ACT_ANY 3'h4

// unit state codes
`define ST_IDLE 3'h0
`define ST_WAIT 3'h1
`define ST_RUN 3'h2
`define ST_DONE 3'h3
`define ST_OVER 3'h4

// interrupt status bit positions
`define IRQ_A_BEGIN 0
`define IRQ_A_FINISH 1
`define IRQ_B_BEGIN 2
`define IRQ_B_FINISH 3
`define IRQ_A_OVER 4
`define IRQ_B_OVER 5
`define IRQ_WIDTH 6

// timing
`define CLK_PERIOD_NS 40
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// File: core/microsecond_tick.v
// one-cycle pulse once per microsecond
`timescale 1ns/100ps
`default_nettype none
`include "event_counter_map.vh"
module microsecond_tick (
  input wire pclk,
  input wire presetn,
  output reg pulse_q
);
  localparam integer LAST_FULL = `TICK_CYCLES - 1;
  localparam [5:0] LAST = LAST_FULL[5:0]; // cut on purpose, the count fits six bits
  reg [5:0] div_q;

  // free-running divider; pulse on wrap
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= 6'h00;
      pulse_q <= 1'b0;
    end
    else
    begin
      div_q <= (div_q == LAST) ? 6'h00 : div_q + 6'h01;
      pulse_q <= (div_q == LAST);
    end
  end
endmodule
`default_nettype wire

// File: core/counter_unit.v
// one event counter unit: qualification, state machine, count and capture
`timescale 1ns/100ps
`default_nettype none
`include "event_counter_map.vh"
module counter_unit (
  input wire pclk,
  input wire presetn,
  input wire enable,
  input wire [31:0] start_limit,
  input wire [31:0] end_limit,
  input wire [2:0] inc_mode,
  input wire [2:0] start_mode,
  input wire [2:0] stop_mode,
  input wire inc_sig,
  input wire inc_pulse,
  input wire start_sig,
  input wire start_pulse,
  input wire start_on,
  input wire stop_sig,
  input wire stop_pulse,
  input wire stop_on,
  input wire cap_wr,
  input wire [31:0] cap_wdata,
  output reg [31:0] count_q,
  output reg [31:0] captured_q,
  output reg [2:0] state_q,
  output reg begin_q,
  output reg finish_q,
  output reg over_q
);
  localparam [2:0] S_IDLE = `ST_IDLE;
  localparam [2:0] S_WAIT = `ST_WAIT;
  localparam [2:0] S_RUN = `ST_RUN;
  localparam [2:0] S_DONE = `ST_DONE;
  localparam [2:0] S_OVER = `ST_OVER;

  reg inc_prev_q, start_prev_q, stop_prev_q;
  reg [31:0] count_d, cap_d;
  reg [2:0] state_d;
  reg begin_d, finish_d, over_d;
  wire inc_hit, start_hit, stop_hit;

  // pulse sources carry no activation; others by level or edge
  function hit;
    input [2:0] m;
    input cur;
    input prev;
    input pulse;
    begin
      if (pulse)
        hit = cur;
      else
        case (m)
          `ACT_LOW: hit = ~cur;
          `ACT_HIGH: hit = cur;
          `ACT_FALL: hit = prev & ~cur;
          `ACT_RISE: hit = ~prev & cur;
          `ACT_ANY: hit = prev ^ cur;
          default: hit = 1'b0;
        endcase
    end
  endfunction

  assign inc_hit = hit(inc_mode, inc_sig, inc_prev_q, inc_pulse);
  assign start_hit = start_on & hit(start_mode, start_sig, start_prev_q, start_pulse);
  assign stop_hit = stop_on & hit(stop_mode, stop_sig, stop_prev_q, stop_pulse);

  // next state; a stop capture overrides a software write of the same cycle
  always @*
  begin
    state_d = state_q;
    count_d = count_q;
    cap_d = cap_wr ? cap_wdata : captured_q;
    begin_d = 1'b0;
    finish_d = 1'b0;
    over_d = 1'b0;
    if (!enable)
      state_d = S_IDLE;
    else
      case (state_q)
        S_IDLE:
        begin
          count_d = 32'h00000000;
          state_d = start_on ? S_WAIT : S_RUN;
        end
        S_WAIT:
          if (start_hit)
          begin
            count_d = 32'h00000000;
            state_d = S_RUN;
          end
        S_RUN:
          if (stop_hit)
          begin
            cap_d = count_q;
            count_d = 32'h00000000;
          end
          else if (inc_hit)
          begin
            if (count_q == 32'hFFFFFFFF)
            begin
              state_d = S_OVER;
              over_d = 1'b1;
            end
            else
            begin
              count_d = count_q + 32'h00000001;
              begin_d = (count_d == start_limit);
              if (count_d == end_limit)
              begin
                finish_d = 1'b1;
                state_d = S_DONE;
              end
            end
          end
        S_DONE, S_OVER:
          if (start_hit)
          begin
            count_d = 32'h00000000;
            state_d = S_RUN;
          end
          else if (stop_hit)
          begin
            cap_d = count_q;
            count_d = 32'h00000000;
            state_d = S_RUN;
          end
        default: state_d = S_IDLE;
      endcase
  end

  // state registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= S_IDLE;
      count_q <= 32'h00000000;
      captured_q <= 32'h00000000;
      begin_q <= 1'b0;
      finish_q <= 1'b0;
      over_q <= 1'b0;
      inc_prev_q <= 1'b0;
      start_prev_q <= 1'b0;
      stop_prev_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
      captured_q <= cap_d;
      begin_q <= begin_d;
      finish_q <= finish_d;
      over_q <= over_d;
      inc_prev_q <= inc_sig;
      start_prev_q <= start_sig;
      stop_prev_q <= stop_sig;
    end
  end
endmodule
`default_nettype wire

// File: core/dual_event_counter_timer.v
// apb register file, source selection and interrupts for two counter units
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "event_counter_map.vh"
module dual_event_counter_timer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [3:0] io_lines,
  input wire [3:0] software_outputs,
  input wire logic_unit_output_a,
  input wire logic_unit_output_b,
  input wire exposure_start,
  input wire exposure_end,
  input wire awaiting_frame_trigger,
  output wire microsecond_pulse,
  output wire unit_a_begin_pulse,
  output wire unit_a_finish_pulse,
  output wire unit_b_begin_pulse,
  output wire unit_b_finish_pulse,
  output reg irq
);
  // per-unit configuration, indexed by unit number
  reg [4:0] inc_src_q [0:1];
  reg [2:0] inc_act_q [0:1];
  reg [31:0] start_lim_q [0:1];
  reg [31:0] end_lim_q [0:1];
  reg [4:0] start_src_q [0:1];
  reg [2:0] start_act_q [0:1];
  reg [4:0] stop_src_q [0:1];
  reg [2:0] stop_act_q [0:1];
  reg [1:0] enable_q;
  reg unit_select_q;
  reg [`IRQ_WIDTH-1:0] irq_status_q;
  reg [`IRQ_WIDTH-1:0] irq_mask_q;
  reg [`IRQ_WIDTH-1:0] irq_set;
  reg [31:0] rd_d;
  reg rd_err;
  integer i;

  wire [31:0] cnt [0:1];
  wire [31:0] cap [0:1];
  wire [2:0] st [0:1];
  wire [1:0] beg;
  wire [1:0] fin;
  wire [1:0] ovf;
  wire [18:0] ev;
  wire wr_en;
  wire rd_phase;
  wire u;

  // event vector, bit index equals source code
  assign ev = {awaiting_frame_trigger, exposure_end, exposure_start,
               logic_unit_output_b, logic_unit_output_a,
               fin[1], fin[0], beg[1], beg[0],
               software_outputs, io_lines, microsecond_pulse, 1'b0};

  assign unit_a_begin_pulse = beg[0];
  assign unit_b_begin_pulse = beg[1];
  assign unit_a_finish_pulse = fin[0];
  assign unit_b_finish_pulse = fin[1];
  assign u = unit_select_q;

  // pick one source; codes past the last read as idle
  function pick;
    input [4:0] sel;
    input [18:0] vec;
    begin
      if (sel > `SRC_LAST)
        pick = 1'b0;
      else
        pick = vec[sel];
    end
  endfunction

  // tick and unit events are pulses with no activation mode
  function is_pulse;
    input [4:0] sel;
    begin
      is_pulse = (sel == `SRC_TICK) ||
                 ((sel >= `SRC_A_BEGIN) && (sel <= `SRC_B_FINISH));
    end
  endfunction

  microsecond_tick tick_gen (
    .pclk(pclk),
    .presetn(presetn),
    .pulse_q(microsecond_pulse)
  );

  // two identical units; unit events feed back only through flops
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : unit
      counter_unit cu (
        .pclk(pclk),
        .presetn(presetn),
        .enable(enable_q[g]),
        .start_limit(start_lim_q[g]),
        .end_limit(end_lim_q[g]),
        .inc_mode(inc_act_q[g]),
        .start_mode(start_act_q[g]),
        .stop_mode(stop_act_q[g]),
        .inc_sig(pick(inc_src_q[g], ev)),
        .inc_pulse(is_pulse(inc_src_q[g])),
        .start_sig(pick(start_src_q[g], ev)),
        .start_pulse(is_pulse(start_src_q[g])),
        .start_on(start_src_q[g] != `SRC_OFF),
        .stop_sig(pick(stop_src_q[g], ev)),
        .stop_pulse(is_pulse(stop_src_q[g])),
        .stop_on(stop_src_q[g] != `SRC_OFF),
        .cap_wr(wr_en && (paddr == `OFS_CAPTURED) && (u == g)),
        .cap_wdata(pwdata),
        .count_q(cnt[g]),
        .captured_q(cap[g]),
        .state_q(st[g]),
        .begin_q(beg[g]),
        .finish_q(fin[g]),
        .over_q(ovf[g])
      );
    end
  endgenerate

  // a write lands at the edge that sees pready high
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_phase = psel & penable & ~pready;

  // read mux for the selected unit; unmapped offsets raise pslverr
  always @*
  begin
    rd_d = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `OFS_UNIT_SELECT: rd_d = {31'h00000000, unit_select_q};
      `OFS_INC_SRC: rd_d = {27'h0000000, inc_src_q[u]};
      `OFS_INC_ACT: rd_d = {29'h00000000, inc_act_q[u]};
      `OFS_START_LIMIT: rd_d = start_lim_q[u];
      `OFS_END_LIMIT: rd_d = end_lim_q[u];
      `OFS_START_SRC: rd_d = {27'h0000000, start_src_q[u]};
      `OFS_START_ACT: rd_d = {29'h00000000, start_act_q[u]};
      `OFS_STOP_SRC: rd_d = {27'h0000000, stop_src_q[u]};
      `OFS_STOP_ACT: rd_d = {29'h00000000, stop_act_q[u]};
      `OFS_LIVE_COUNT: rd_d = cnt[u];
      `OFS_CAPTURED: rd_d = cap[u];
      `OFS_UNIT_STATE: rd_d = {29'h00000000, st[u]};
      `OFS_CONTROL: rd_d = {31'h00000000, enable_q[u]};
      `OFS_IRQ_STATUS: rd_d = {26'h0000000, irq_status_q};
      `OFS_IRQ_MASK: rd_d = {26'h0000000, irq_mask_q};
      default: rd_err = 1'b1;
    endcase
  end

  // apb answer: one wait state, data and error registered with pready
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rd_phase;
      pslverr <= rd_phase & rd_err;
      if (rd_phase && !pwrite)
        prdata <= rd_d;
      else
        prdata <= 32'h00000000;
    end
  end

  // configuration writes go to the selected unit; unit select and irq mask are shared
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_select_q <= 1'b0;
      enable_q <= 2'b00;
      for (i = 0; i < 2; i = i + 1)
      begin
        inc_src_q[i] <= `SRC_OFF;
        inc_act_q[i] <= `ACT_RISE;
        start_lim_q[i] <= 32'h00000000;
        end_lim_q[i] <= 32'h00000000;
        start_src_q[i] <= `SRC_OFF;
        start_act_q[i] <= `ACT_RISE;
        stop_src_q[i] <= `SRC_OFF;
        stop_act_q[i] <= `ACT_RISE;
      end
      irq_mask_q <= 6'h00;
    end
    else if (wr_en)
    begin
      case (paddr)
        `OFS_UNIT_SELECT: unit_select_q <= pwdata[0];
        `OFS_INC_SRC: inc_src_q[u] <= pwdata[4:0];
        `OFS_INC_ACT: inc_act_q[u] <= pwdata[2:0];
        `OFS_START_LIMIT: start_lim_q[u] <= pwdata;
        `OFS_END_LIMIT: end_lim_q[u] <= pwdata;
        `OFS_START_SRC:
        begin
          start_src_q[u] <= pwdata[4:0];
          if (pwdata[4:0] != `SRC_OFF)
            stop_src_q[u] <= `SRC_OFF;
        end
        `OFS_START_ACT: start_act_q[u] <= pwdata[2:0];
        `OFS_STOP_SRC:
        begin
          stop_src_q[u] <= pwdata[4:0];
          if (pwdata[4:0] != `SRC_OFF)
            start_src_q[u] <= `SRC_OFF;
        end
        `OFS_STOP_ACT: stop_act_q[u] <= pwdata[2:0];
        `OFS_CONTROL: enable_q[u] <= pwdata[0];
        `OFS_IRQ_MASK: irq_mask_q <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // unit events, gathered in status bit order
  always @*
  begin
    irq_set = 6'h00;
    irq_set[`IRQ_A_BEGIN] = beg[0];
    irq_set[`IRQ_A_FINISH] = fin[0];
    irq_set[`IRQ_B_BEGIN] = beg[1];
    irq_set[`IRQ_B_FINISH] = fin[1];
    irq_set[`IRQ_A_OVER] = ovf[0];
    irq_set[`IRQ_B_OVER] = ovf[1];
  end

  // sticky status, write one to clear; a same-cycle event wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status_q <= 6'h00;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_en && (paddr == `OFS_IRQ_STATUS))
        irq_status_q <= (irq_status_q & ~pwdata[5:0]) | irq_set;
      else
        irq_status_q <= irq_status_q | irq_set;
      irq <= |(irq_status_q & irq_mask_q); // one cycle behind status
    end
  end
endmodule
`default_nettype wire

// File: verification/event_counter_monitor.sv
// concurrent checks on the register bus, tick and unit pulses
`timescale 1ns/100ps
`default_nettype none
module event_counter_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic microsecond_pulse,
  input wire logic unit_a_begin_pulse,
  input wire logic unit_b_finish_pulse
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // a fresh transfer: setup, then the first access cycle
  sequence setup_then_access;
    psel && !penable ##1 psel && penable;
  endsequence
  // the answer comes after exactly one wait state
  sequence one_wait_answer;
    !pready ##1 pready;
  endsequence

  AST_APB_WAIT: assert property (setup_then_access |-> one_wait_answer)
    else $error("answer not after one wait state");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_READY_IDLE: assert property (!(psel && penable) |=> !pready)
    else $error("ready without an access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error flag outside the answer cycle");
  AST_RDATA_QUIET: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data not zero outside the answer");
  // the tick period is 25 cycles of the 40 ns clock
  AST_TICK_PERIOD: assert property (microsecond_pulse |-> ##25 microsecond_pulse)
    else $error("tick period is not 25 cycles");
  AST_TICK_SINGLE: assert property (microsecond_pulse |=> !microsecond_pulse [*8])
    else $error("tick not a lone pulse");
  AST_A_BEGIN_SINGLE: assert property (unit_a_begin_pulse |=> !unit_a_begin_pulse)
    else $error("begin pulse longer than one cycle");
  AST_B_FINISH_SINGLE: assert property (unit_b_finish_pulse |=> !unit_b_finish_pulse)
    else $error("finish pulse longer than one cycle");
endmodule

bind dual_event_counter_timer event_counter_monitor event_counter_monitor_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .microsecond_pulse(microsecond_pulse), .unit_a_begin_pulse(unit_a_begin_pulse),
  .unit_b_finish_pulse(unit_b_finish_pulse));
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the dual event counter timer
`timescale 1ns/100ps
`default_nettype none
`include "event_counter_map.vh"
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [18:0] ev = 19'h00000;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire unit_a_begin_pulse;
  wire unit_b_finish_pulse;
  wire unit_a_finish_pulse;
  wire unit_b_begin_pulse;
  wire microsecond_pulse;
  wire irq;
  int bad_count = 0;
  int tests_run = 0;
  int a_beg = 0;
  int b_fin = 0;
  int a_fin = 0;
  int b_beg = 0;
  int ticks = 0;
  int t0;
  int n;
  logic [31:0] v;
  logic pat [0:33];
  logic [31:0] rd;
  logic er;
  logic [2:0] m;
  logic idle;
  logic [18:0] r;

  always #20 pclk = ~pclk;

  // event inputs are bits of one vector, indexed by source code
  dual_event_counter_timer dual_event_counter_timer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_lines(ev[5:2]),
    .software_outputs(ev[9:6]), .logic_unit_output_a(ev[14]),
    .logic_unit_output_b(ev[15]), .exposure_start(ev[16]), .exposure_end(ev[17]),
    .awaiting_frame_trigger(ev[18]), .microsecond_pulse(microsecond_pulse),
    .unit_a_begin_pulse(unit_a_begin_pulse), .unit_a_finish_pulse(unit_a_finish_pulse),
    .unit_b_begin_pulse(unit_b_begin_pulse), .unit_b_finish_pulse(unit_b_finish_pulse),
    .irq(irq));

  // tally of pulses, one per high cycle; mid-cycle so no race with the edge
  always @(negedge pclk)
  begin
    a_beg += int'(unit_a_begin_pulse);
    b_fin += int'(unit_b_finish_pulse);
    a_fin += int'(unit_a_finish_pulse);
    b_beg += int'(unit_b_begin_pulse);
    ticks += int'(microsecond_pulse);
  end

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      bad_count++;
      end_sim();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, rd, er);
    check(rd, exp);
  endtask

  task automatic pulse(input int k, input int cnt);
    repeat (cnt)
    begin
      ev[k] <= 1'b1;
      @(posedge pclk);
      ev[k] <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // qualified count of the stored pattern; level modes count every cycle at the active level
  function automatic logic [31:0] expect_count(input logic [2:0] md);
    logic [31:0] c;
    c = 32'h00000000;
    for (int i = 1; i <= 33; i++)
      case (md)
        `ACT_LOW: c += {31'h0, !pat[i]};
        `ACT_HIGH: c += {31'h0, pat[i]};
        `ACT_FALL: c += {31'h0, pat[i-1] & !pat[i]};
        `ACT_RISE: c += {31'h0, !pat[i-1] & pat[i]};
        default: c += {31'h0, pat[i-1] ^ pat[i]};
      endcase
    return c;
  endfunction

  // main sequence
  initial
  begin
    void'($urandom(67));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(`OFS_INC_ACT, 32'h00000003);
    rc(`OFS_STOP_ACT, 32'h00000003);
    rc(`OFS_UNIT_STATE, {29'h0, `ST_IDLE});
    wr(`OFS_LIVE_COUNT, 32'h00000005);
    rc(`OFS_LIVE_COUNT, 32'h00000000);
    apb(1'b0, 8'h3C, 32'h00000000, rd, er);
    check({31'h0, er}, 32'h00000001);
    // every external source with a mode; other sources toggle as noise
    for (int s = 2; s <= 18; s++)
    begin
      if (s < 10 || s > 13)
      begin
        m = 3'(s % 5);
        idle = (m == `ACT_LOW);
        ev <= {19{idle}};
        wr(`OFS_CONTROL, 32'h00000000);
        wr(`OFS_INC_SRC, 32'(s));
        wr(`OFS_INC_ACT, {29'h0, m});
        wr(`OFS_CONTROL, 32'h00000001);
        repeat (3) @(posedge pclk);
        pat[0] = idle;
        pat[33] = idle;
        for (int i = 1; i <= 33; i++)
        begin
          if (i < 33)
            pat[i] = 1'($urandom);
          r = 19'($urandom);
          r[s] = pat[i];
          ev <= r;
          @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
        rc(`OFS_LIVE_COUNT, expect_count(m));
      end
    end
    // begin at 2, finish at 5, extra edges ignored once done
    ev <= 19'h00000;
    wr(`OFS_CONTROL, 32'h00000000);
    wr(`OFS_INC_SRC, 32'h00000002);
    wr(`OFS_INC_ACT, 32'h00000003);
    wr(`OFS_START_LIMIT, 32'h00000002);
    wr(`OFS_END_LIMIT, 32'h00000005);
    wr(`OFS_IRQ_MASK, 32'h00000003);
    wr(`OFS_CONTROL, 32'h00000001);
    repeat (3) @(posedge pclk);
    pulse(2, 7);
    repeat (3) @(posedge pclk);
    check(32'(a_beg), 32'h00000001);
    check(32'(a_fin), 32'h00000001);
    rc(`OFS_LIVE_COUNT, 32'h00000005);
    rc(`OFS_UNIT_STATE, {29'h0, `ST_DONE});
    check({31'h0, irq}, 32'h00000001);
    rc(`OFS_IRQ_STATUS, 32'h00000003);
    wr(`OFS_IRQ_STATUS, 32'h00000003);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h00000000);
    // stop source captures the held count and clears it
    wr(`OFS_STOP_SRC, 32'h00000003);
    pulse(3, 1);
    repeat (2) @(posedge pclk);
    rc(`OFS_CAPTURED, 32'h00000005);
    v = $urandom;
    wr(`OFS_CAPTURED, v);
    rc(`OFS_CAPTURED, v);
    rc(`OFS_LIVE_COUNT, 32'h00000000);
    rc(`OFS_UNIT_STATE, {29'h0, `ST_RUN});
    wr(`OFS_START_SRC, 32'h00000004);
    rc(`OFS_STOP_SRC, 32'h00000000);
    wr(`OFS_CONTROL, 32'h00000000);
    wr(`OFS_CONTROL, 32'h00000001);
    repeat (3) @(posedge pclk);
    rc(`OFS_UNIT_STATE, {29'h0, `ST_WAIT});
    pulse(4, 1);
    repeat (2) @(posedge pclk);
    rc(`OFS_UNIT_STATE, {29'h0, `ST_RUN});
    wr(`OFS_STOP_SRC, 32'h00000003);
    rc(`OFS_START_SRC, 32'h00000000);
    // activation codes past any-edge never count
    wr(`OFS_INC_ACT, {29'h0, 3'(5 + $urandom % 3)});
    pulse(2, 3);
    repeat (2) @(posedge pclk);
    rc(`OFS_LIVE_COUNT, 32'h00000000);
    // second unit counts ticks; its begin and finish are masked
    wr(`OFS_UNIT_SELECT, 32'h00000001);
    rc(`OFS_INC_SRC, 32'h00000000);
    wr(`OFS_INC_SRC, 32'h00000001);
    wr(`OFS_START_LIMIT, 32'h00000002);
    wr(`OFS_END_LIMIT, 32'h00000003);
    wr(`OFS_CONTROL, 32'h00000001);
    n = 0;
    while (b_fin == 0 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300)
    begin
      bad_count++;
      end_sim();
    end
    check(32'(b_fin), 32'h00000001);
    check(32'(b_beg), 32'h00000001);
    repeat (2) @(posedge pclk);
    rc(`OFS_LIVE_COUNT, 32'h00000003);
    check({31'h0, irq}, 32'h00000000);
    rc(`OFS_IRQ_STATUS, 32'h0000000C);
    // ten tick periods fit exactly in 250 cycles, whatever the phase
    t0 = ticks;
    repeat (250) @(posedge pclk);
    check(32'(ticks - t0), 32'h0000000A);
    wr(`OFS_UNIT_SELECT, 32'h00000000);
    rc(`OFS_LIVE_COUNT, 32'h00000000);
    end_sim();
  end
endmodule
`default_nettype wire
